/* rtl/fpic_top.sv */
// cyclic process image decoder and status encoder for the pump module
// What this block does
// - thirty-two bytes each way per cycle
// - alarm when either configured image size is not thirty-two bytes
// - demands and actuals in 0.01 percent
// - pressures in tenths of a bar
// - control and status one means active
// - error flags reported inverted, zero is error
// - system enable ANDed with hardware enable
// - pressure loop and ramp follow bits
// - power cap scaled by demand word
// - set two select; sensor two open-circuit only
// - parameter fetch returns value, invalid all ones
// - lower select returns lower range limit
// - writes only in write mode, reported
// - value taken on valid rising edge
// - param ready set on success, cleared by valid
// - live bit arms one second watchdog
// - live bit echoed into status word
// - ready needs enable and no error
// - bus error on overflow, checksum, watchdog
// - status word carries limit and fault flags
// - feedback carries measured values and parameter
// - output image big-endian byte layout
// - upper select returns upper range limit
// - control word one bit assignment
// - control word two bit assignment
// - feedback image byte layout
`timescale 1ns/10ps
module fpic_top #(
  parameter int WDOG_LIMIT = fpic_pkg::WDOG_CYCLES,
  parameter int STORE_DEPTH = fpic_pkg::PSTORE_DEPTH
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [255:0] OUT_IMAGE,
  input wire logic OUT_STROBE,
  input wire logic [7:0] CFG_OUT_LEN,
  input wire logic [7:0] CFG_IN_LEN,
  input wire logic BUF_OVERFLOW,
  input wire logic CRC_FAIL,
  input wire logic HW_ENABLE,
  input wire logic OPEN_CIRCUIT,
  input wire logic POWER_CAPPED,
  input wire logic PRESSURE_LIMITED,
  input wire logic SWIVEL_FAULT,
  input wire logic PRESSURE_ONE_FAULT,
  input wire logic PRESSURE_TWO_FAULT,
  input wire logic SOLENOID_A_FAULT,
  input wire logic SOLENOID_B_FAULT,
  input wire logic INTERNAL_DATA_FAULT,
  input wire logic [15:0] ACT_SWIVEL,
  input wire logic [15:0] ACT_PRESSURE_ONE,
  input wire logic [15:0] ACT_PRESSURE_TWO,
  input wire logic [15:0] ACT_LIMIT_OUT,
  input wire logic [15:0] ACT_VALVE,
  input wire logic [15:0] ACT_SOLENOID_A,
  input wire logic [15:0] ACT_SOLENOID_B,
  input wire logic [15:0] ACT_SPOOL,
  output logic [255:0] IN_IMAGE,
  output logic SIZE_ALARM,
  output logic SWIVEL_RUN,
  output logic PRESSURE_LOOP_ON,
  output logic RAMP_ON,
  output logic POWER_CAP_ON,
  output logic PRESSURE_SET_TWO,
  output logic FEEDBACK_SENSOR_TWO,
  output logic [15:0] SWIVEL_DEMAND,
  output logic [15:0] PRESSURE_DEMAND,
  output logic [15:0] POWER_CAP_DEMAND,
  output logic READY,
  output logic BUS_FAULT,
  output logic PARAM_WRITTEN
);
  typedef struct packed {
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] swivel;
    logic [15:0] press;
    logic [15:0] pcap;
    logic [255:0] prev_img;
    logic valid_prev;
    logic param_ready;
    logic [31:0] param_rd;
    logic armed;
    logic [31:0] wd_cnt;
    logic bus_fault;
    logic size_alarm;
    logic wr_pulse;
    logic swivel_run;
    logic ploop;
    logic ramp;
    logic pcap_on;
    logic set_two;
    logic fb_two;
    logic ready;
    logic [255:0] in_img;
  } fpic_state_t;

  fpic_state_t st_reg;
  fpic_state_t st_next;

  logic [15:0] rx_ctl1;
  logic [15:0] rx_ctl2;
  logic [15:0] rx_paddr;
  logic [31:0] rx_pval;
  logic [31:0] store_value;
  logic [31:0] store_lower;
  logic [31:0] store_upper;
  logic store_addr_ok;
  logic store_data_ok;
  logic wr_fire;

  // big-endian word at a byte offset, byte 0 sits in the top bits
  function automatic logic [15:0] fpic_word(input logic [255:0] img, input int off);
    fpic_word = img[255 - 8 * off -: 16];
  endfunction : fpic_word

  function automatic logic [31:0] fpic_long(input logic [255:0] img, input int off);
    fpic_long = img[255 - 8 * off -: 32];
  endfunction : fpic_long

  always_comb begin
    rx_ctl1 = fpic_word(OUT_IMAGE, fpic_pkg::OB_CTL1);
    rx_ctl2 = fpic_word(OUT_IMAGE, fpic_pkg::OB_CTL2);
    rx_pval = fpic_long(OUT_IMAGE, fpic_pkg::OB_PVAL);
    rx_paddr = fpic_word(OUT_IMAGE, fpic_pkg::OB_PADDR);
  end

  // a write fires on the valid edge only while write mode is set
  always_comb begin
    wr_fire = OUT_STROBE && rx_ctl2[fpic_pkg::C2_PVALID] && !st_reg.valid_prev &&
              rx_ctl2[fpic_pkg::C2_WR_MODE];
  end

  fpic_param_store #(
    .DEPTH(STORE_DEPTH),
    .LOWER(fpic_pkg::PLIM_LOWER),
    .UPPER(fpic_pkg::PLIM_UPPER)
  ) u_store (
    .clk(MCLK),
    .rst(RESET),
    .addr(OUT_STROBE ? rx_paddr : st_reg.prev_img[255 - 8 * fpic_pkg::OB_PADDR -: 16]),
    .wr_en(wr_fire),
    .wr_data(rx_pval),
    .rd_value(store_value),
    .rd_lower(store_lower),
    .rd_upper(store_upper),
    .addr_ok(store_addr_ok),
    .data_ok(store_data_ok)
  );

  always_comb begin
    logic [15:0] c1;
    logic [15:0] c2;
    logic fault_any;
    logic [15:0] sw1;
    logic [15:0] sw2;
    c1 = '0;
    c2 = '0;
    fault_any = 1'b0;
    sw1 = '0;
    sw2 = '0;
    st_next = st_reg;
    st_next.wr_pulse = 1'b0;

    // image size must match the internal layout in both directions
    st_next.size_alarm = (CFG_OUT_LEN != 8'(fpic_pkg::IMG_BYTES)) ||
                         (CFG_IN_LEN != 8'(fpic_pkg::IMG_BYTES));

    if (OUT_STROBE) begin
      st_next.ctl1 = rx_ctl1;
      st_next.ctl2 = rx_ctl2;
      // demands pass through unchanged in 0.01 % and 0.1 bar units
      st_next.swivel = fpic_word(OUT_IMAGE, fpic_pkg::OB_SWIVEL);
      st_next.press = fpic_word(OUT_IMAGE, fpic_pkg::OB_PRESS);
      st_next.pcap = fpic_word(OUT_IMAGE, fpic_pkg::OB_PCAP);
      st_next.prev_img = OUT_IMAGE;
      st_next.valid_prev = rx_ctl2[fpic_pkg::C2_PVALID];

      // fetch path: limits take priority over the present value
      if (rx_ctl2[fpic_pkg::C2_FETCH]) begin
        if (rx_ctl2[fpic_pkg::C2_LOWER_SEL]) begin
          st_next.param_rd = store_lower;
        end else if (rx_ctl2[fpic_pkg::C2_UPPER_SEL]) begin
          st_next.param_rd = store_upper;
        end else begin
          st_next.param_rd = store_value;
        end
      end

      // ready drops with valid; a good write in the same frame sets it
      if (!rx_ctl2[fpic_pkg::C2_PVALID]) begin
        st_next.param_ready = 1'b0;
      end
      if (!rx_ctl2[fpic_pkg::C2_WR_MODE]) begin
        st_next.param_ready = 1'b0;
      end
      if (wr_fire && store_addr_ok && store_data_ok) begin
        st_next.param_ready = 1'b1;
        st_next.wr_pulse = 1'b1;
      end

      // disabling the system is how software clears a latched bus error
      if (!rx_ctl1[fpic_pkg::C1_SYS_EN]) begin
        st_next.bus_fault = 1'b0;
      end
    end

    // watchdog: armed by live bit while ready, restarted by any data change
    if (st_reg.armed) begin
      if (OUT_STROBE && (OUT_IMAGE != st_reg.prev_img)) begin
        st_next.wd_cnt = '0;
      end else if (st_reg.wd_cnt >= 32'(WDOG_LIMIT - 1)) begin
        st_next.armed = 1'b0;
        st_next.wd_cnt = '0;
        st_next.bus_fault = 1'b1;
      end else begin
        st_next.wd_cnt = st_reg.wd_cnt + 32'h00000001;
      end
      if (!st_reg.ctl2[fpic_pkg::C2_LIVE_IN] && !st_reg.ready) begin
        st_next.armed = 1'b0;
        st_next.wd_cnt = '0;
      end
    end else if (st_reg.ready && st_reg.ctl2[fpic_pkg::C2_LIVE_IN]) begin
      st_next.armed = 1'b1;
      st_next.wd_cnt = '0;
    end

    // link errors set last so they win over a same-cycle clear
    if (BUF_OVERFLOW || CRC_FAIL) begin
      st_next.bus_fault = 1'b1;
    end

    c1 = st_next.ctl1;
    c2 = st_next.ctl2;

    fault_any = SWIVEL_FAULT || PRESSURE_ONE_FAULT || PRESSURE_TWO_FAULT ||
                SOLENOID_A_FAULT || SOLENOID_B_FAULT || INTERNAL_DATA_FAULT ||
                st_next.bus_fault || st_next.size_alarm;

    // decoded commands, one means active
    st_next.swivel_run = c1[fpic_pkg::C1_SYS_EN] && HW_ENABLE;
    st_next.ploop = c1[fpic_pkg::C1_PLOOP_EN];
    st_next.ramp = c1[fpic_pkg::C1_RAMP_EN];
    st_next.pcap_on = c1[fpic_pkg::C1_PCAP_EN];
    st_next.set_two = c1[fpic_pkg::C1_SET_SEL];
    st_next.fb_two = c1[fpic_pkg::C1_FB_SEL] && OPEN_CIRCUIT;
    st_next.ready = st_next.swivel_run && !fault_any;

    // status word one
    sw1[fpic_pkg::S1_READY] = st_next.ready;
    sw1[fpic_pkg::S1_PCAPPED] = POWER_CAPPED;
    sw1[fpic_pkg::S1_PLIMITED] = PRESSURE_LIMITED;
    sw1[fpic_pkg::S1_BUS_OK] = !st_next.bus_fault;
    sw1[fpic_pkg::S1_PACTIVE] = c2[fpic_pkg::C2_WR_MODE];
    sw1[fpic_pkg::S1_PREADY] = st_next.param_ready;
    sw1[fpic_pkg::S1_LIVE_OUT] = c2[fpic_pkg::C2_LIVE_IN];
    // status word two: error flags inverted
    sw2[fpic_pkg::S2_SWIVEL_OK] = !SWIVEL_FAULT;
    sw2[fpic_pkg::S2_P1_OK] = !PRESSURE_ONE_FAULT;
    sw2[fpic_pkg::S2_P2_OK] = !PRESSURE_TWO_FAULT;
    sw2[fpic_pkg::S2_SOLA_OK] = !SOLENOID_A_FAULT;
    sw2[fpic_pkg::S2_SOLB_OK] = !SOLENOID_B_FAULT;
    sw2[fpic_pkg::S2_DATA_OK] = !INTERNAL_DATA_FAULT;

    // feedback image, big-endian, spare bytes 20..27 read zero
    st_next.in_img = {sw1, sw2, ACT_SWIVEL, ACT_PRESSURE_ONE,
                      ACT_PRESSURE_TWO, ACT_LIMIT_OUT, ACT_VALVE,
                      ACT_SOLENOID_A, ACT_SOLENOID_B, ACT_SPOOL,
                      64'h0000000000000000, st_next.param_rd};
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign IN_IMAGE = st_reg.in_img;
  assign SIZE_ALARM = st_reg.size_alarm;
  assign SWIVEL_RUN = st_reg.swivel_run;
  assign PRESSURE_LOOP_ON = st_reg.ploop;
  assign RAMP_ON = st_reg.ramp;
  assign POWER_CAP_ON = st_reg.pcap_on;
  assign PRESSURE_SET_TWO = st_reg.set_two;
  assign FEEDBACK_SENSOR_TWO = st_reg.fb_two;
  assign SWIVEL_DEMAND = st_reg.swivel;
  assign PRESSURE_DEMAND = st_reg.press;
  assign POWER_CAP_DEMAND = st_reg.pcap;
  assign READY = st_reg.ready;
  assign BUS_FAULT = st_reg.bus_fault;
  assign PARAM_WRITTEN = st_reg.wr_pulse;
endmodule : fpic_top

/* rtl/fpic_pkg.sv */
// constants for the fieldbus process image controller
package fpic_pkg;
  localparam int IMG_BYTES = 32;
  localparam int IMG_BITS = 256;

  // output image (controller to module) byte offsets
  localparam int OB_CTL1 = 0;
  localparam int OB_CTL2 = 2;
  localparam int OB_SWIVEL = 4;
  localparam int OB_PRESS = 6;
  localparam int OB_PCAP = 8;
  localparam int OB_PVAL = 26;
  localparam int OB_PADDR = 30;
  localparam logic [15:0] PADDR_MAX = 16'h2065;

  // control word one bits
  localparam int C1_FB_SEL = 8;
  localparam int C1_SET_SEL = 9;
  localparam int C1_PCAP_EN = 12;
  localparam int C1_RAMP_EN = 13;
  localparam int C1_PLOOP_EN = 14;
  localparam int C1_SYS_EN = 15;
  // control word two bits
  localparam int C2_LIVE_IN = 8;
  localparam int C2_LOWER_SEL = 3;
  localparam int C2_UPPER_SEL = 4;
  localparam int C2_FETCH = 5;
  localparam int C2_PVALID = 6;
  localparam int C2_WR_MODE = 7;

  // status word one bits
  localparam int S1_READY = 15;
  localparam int S1_PCAPPED = 14;
  localparam int S1_PLIMITED = 13;
  localparam int S1_BUS_OK = 12;
  localparam int S1_PACTIVE = 11;
  localparam int S1_PREADY = 10;
  localparam int S1_LIVE_OUT = 8;
  // status word two bits, error flags read one while healthy
  localparam int S2_SWIVEL_OK = 15;
  localparam int S2_P1_OK = 14;
  localparam int S2_P2_OK = 13;
  localparam int S2_SOLA_OK = 12;
  localparam int S2_SOLB_OK = 11;
  localparam int S2_DATA_OK = 10;

  localparam logic [31:0] PVAL_INVALID = 32'hFFFFFFFF;
  localparam logic [15:0] DEMAND_FULL = 16'h2710;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [31:0] RESET_LONG = 32'h00000000;

  // live bit watchdog
  localparam int LIVE_TIMEOUT_MS = 1000;
  localparam int CLK_KHZ = 100000;
  localparam int WDOG_CYCLES = LIVE_TIMEOUT_MS * CLK_KHZ;

  // parameter store defaults
  localparam int PSTORE_DEPTH = 64;
  localparam logic [31:0] PLIM_LOWER = 32'h00000000;
  localparam logic [31:0] PLIM_UPPER = 32'h7FFFFFFF;
endpackage : fpic_pkg

/* rtl/fpic_param_store.sv */
// parameter memory with range limits and address validation
`timescale 1ns/10ps
module fpic_param_store #(
  parameter int DEPTH = fpic_pkg::PSTORE_DEPTH,
  parameter logic [31:0] LOWER = fpic_pkg::PLIM_LOWER,
  parameter logic [31:0] UPPER = fpic_pkg::PLIM_UPPER
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_value,
  output logic [31:0] rd_lower,
  output logic [31:0] rd_upper,
  output logic addr_ok,
  output logic data_ok
);
  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
  } fpic_store_t;

  fpic_store_t st_reg;
  fpic_store_t st_next;

  // only a slice of the address space is backed; the rest reads invalid
  assign addr_ok = (addr < 16'(DEPTH)) && (addr <= fpic_pkg::PADDR_MAX);
  assign data_ok = ($signed(wr_data) >= $signed(LOWER)) &&
                   ($signed(wr_data) <= $signed(UPPER));

  always_comb begin
    rd_value = fpic_pkg::PVAL_INVALID;
    rd_lower = fpic_pkg::PVAL_INVALID;
    rd_upper = fpic_pkg::PVAL_INVALID;
    if (addr_ok) begin
      rd_value = st_reg.mem[addr[$clog2(DEPTH)-1:0]];
      rd_lower = LOWER;
      rd_upper = UPPER;
    end
  end

  always_comb begin
    st_next = st_reg;
    if (wr_en && addr_ok && data_ok) begin
      st_next.mem[addr[$clog2(DEPTH)-1:0]] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : fpic_param_store

/* bench/fpic_sva.sv */
// port-level assertion checker for the process image controller
`timescale 1ns/10ps
module fpic_sva #(
  parameter int WDOG_LIMIT = fpic_pkg::WDOG_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [255:0] OUT_IMAGE,
  input wire logic OUT_STROBE,
  input wire logic [7:0] CFG_OUT_LEN,
  input wire logic [7:0] CFG_IN_LEN,
  input wire logic CRC_FAIL,
  input wire logic HW_ENABLE,
  input wire logic OPEN_CIRCUIT,
  input wire logic SWIVEL_FAULT,
  input wire logic INTERNAL_DATA_FAULT,
  input wire logic [15:0] ACT_SWIVEL,
  input wire logic [255:0] IN_IMAGE,
  input wire logic SIZE_ALARM,
  input wire logic SWIVEL_RUN,
  input wire logic PRESSURE_LOOP_ON,
  input wire logic FEEDBACK_SENSOR_TWO,
  input wire logic [15:0] SWIVEL_DEMAND,
  input wire logic READY,
  input wire logic BUS_FAULT,
  input wire logic PARAM_WRITTEN
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  int stall_cnt;
  // frames that repeat the previous image; margin below absorbs the design's count offset
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      stall_cnt <= 0;
    end else if (OUT_STROBE && $stable(OUT_IMAGE)) begin
      stall_cnt <= stall_cnt + 1;
    end else begin
      stall_cnt <= 0;
    end
  end
  sys_run_a: assert property (OUT_STROBE |=>
    SWIVEL_RUN == ($past(OUT_IMAGE[255]) & $past(HW_ENABLE))) else $error("run gating");
  loop_on_a: assert property (OUT_STROBE |=>
    PRESSURE_LOOP_ON == $past(OUT_IMAGE[254])) else $error("loop enable");
  fb_sel_a: assert property (OUT_STROBE |=>
    FEEDBACK_SENSOR_TWO == ($past(OUT_IMAGE[248]) & $past(OPEN_CIRCUIT))) else $error("fb sel");
  demand_word_a: assert property (OUT_STROBE |=>
    SWIVEL_DEMAND == $past(OUT_IMAGE[223:208])) else $error("demand word");
  // one cycle of history is enough: the flops load from the first edge after release
  size_alarm_a: assert property (!$past(RESET) |->
    SIZE_ALARM == $past(CFG_OUT_LEN != 8'h20 || CFG_IN_LEN != 8'h20)) else $error("size alarm");
  live_echo_a: assert property (OUT_STROBE |=>
    IN_IMAGE[248] == $past(OUT_IMAGE[232])) else $error("live echo");
  err_inverted_a: assert property (!$past(RESET) |->
    {IN_IMAGE[239], IN_IMAGE[234]} == ~{$past(SWIVEL_FAULT), $past(INTERNAL_DATA_FAULT)})
    else $error("error flag polarity");
  actual_pass_a: assert property (!$past(RESET) |->
    IN_IMAGE[223:208] == $past(ACT_SWIVEL)) else $error("actual swivel");
  write_gate_a: assert property (PARAM_WRITTEN |->
    ($past(OUT_STROBE) && $past(OUT_IMAGE[231:230]) == 2'b11) ##1 !PARAM_WRITTEN)
    else $error("param write gating");
  bus_set_a: assert property (CRC_FAIL |-> ##[1:2] BUS_FAULT) else $error("bus fault");
  bus_ready_a: assert property (BUS_FAULT |=> !READY) else $error("ready with fault");
  ready_hw_a: assert property (READY |-> $past(HW_ENABLE)) else $error("ready no enable");
  wdog_drop_a: assert property (stall_cnt > WDOG_LIMIT + 4 && OUT_IMAGE[232] |->
    !READY) else $error("watchdog");
  write_seen_c: cover property (PARAM_WRITTEN);
  fault_seen_c: cover property ($rose(BUS_FAULT));
  alarm_seen_c: cover property (SIZE_ALARM);
endmodule : fpic_sva

bind fpic_top fpic_sva #(.WDOG_LIMIT(WDOG_LIMIT)) sva_u (.*);

/* bench/fpic_plc_model.sv */
// stand-in for the fieldbus controller that sends the cyclic output image
`timescale 1ns/10ps
module fpic_plc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic live_toggle,
  input wire logic [15:0] ctl1,
  input wire logic [15:0] ctl2,
  input wire logic [15:0] swivel,
  input wire logic [15:0] press,
  input wire logic [15:0] pcap,
  input wire logic [31:0] pval,
  input wire logic [15:0] paddr,
  output logic [255:0] image,
  output logic strobe
);
  logic live_reg;
  // stopping the toggle is how the bench starves the watchdog
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reg <= 1'b0;
    end else if (live_toggle) begin
      live_reg <= ~live_reg;
    end
  end
  assign strobe = run;
  assign image = {ctl1, ctl2[15:9], ctl2[8] | live_reg, ctl2[7:0], swivel, press, pcap,
    128'h0, pval, paddr};
endmodule : fpic_plc_model

/* bench/fpic_top_bench.sv */
// self-checking bench for the process image controller
`timescale 1ns/10ps
module fpic_top_bench;
  localparam int WDOG = 50;
  logic MCLK, RESET, OUT_STROBE, BUF_OVERFLOW, CRC_FAIL, HW_ENABLE, OPEN_CIRCUIT;
  logic POWER_CAPPED, PRESSURE_LIMITED, SWIVEL_FAULT, PRESSURE_ONE_FAULT, PRESSURE_TWO_FAULT;
  logic SOLENOID_A_FAULT, SOLENOID_B_FAULT, INTERNAL_DATA_FAULT, run, tog;
  logic SIZE_ALARM, SWIVEL_RUN, PRESSURE_LOOP_ON, RAMP_ON, POWER_CAP_ON, PRESSURE_SET_TWO;
  logic FEEDBACK_SENSOR_TWO, READY, BUS_FAULT, PARAM_WRITTEN;
  logic [7:0] CFG_OUT_LEN, CFG_IN_LEN;
  logic [15:0] ACT_SWIVEL, ACT_PRESSURE_ONE, ACT_PRESSURE_TWO, ACT_LIMIT_OUT, ACT_VALVE;
  logic [15:0] ACT_SOLENOID_A, ACT_SOLENOID_B, ACT_SPOOL, SWIVEL_DEMAND, PRESSURE_DEMAND;
  logic [15:0] POWER_CAP_DEMAND, c1, c2, sw, pr, pc, pa;
  logic [255:0] OUT_IMAGE, IN_IMAGE;
  logic [127:0] act;
  logic [31:0] pv, r, q;
  logic [5:0] flt;
  int bad_count, total_checks, seed;
  logic [15:0] sel [5] = '{16'h0020, 16'h0028, 16'h0030, 16'h0038, 16'h0020};
  logic [31:0] fexp [5] = '{32'h12345678, fpic_pkg::PLIM_LOWER, fpic_pkg::PLIM_UPPER,
    fpic_pkg::PLIM_LOWER, fpic_pkg::PVAL_INVALID};

  assign {SWIVEL_FAULT, PRESSURE_ONE_FAULT, PRESSURE_TWO_FAULT, SOLENOID_A_FAULT,
    SOLENOID_B_FAULT, INTERNAL_DATA_FAULT} = flt;
  assign {ACT_SWIVEL, ACT_PRESSURE_ONE, ACT_PRESSURE_TWO, ACT_LIMIT_OUT, ACT_VALVE,
    ACT_SOLENOID_A, ACT_SOLENOID_B, ACT_SPOOL} = act;

  fpic_top #(.WDOG_LIMIT(WDOG)) dut_u (.*);
  fpic_plc_model plc_u (.clk(MCLK), .rst(RESET), .run(run), .live_toggle(tog), .ctl1(c1),
    .ctl2(c2), .swivel(sw), .press(pr), .pcap(pc), .pval(pv), .paddr(pa),
    .image(OUT_IMAGE), .strobe(OUT_STROBE));

  function automatic logic [15:0] exp_status2(input logic [5:0] f);
    return {~f, 10'h000};
  endfunction : exp_status2

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : step

  // value and address go out with the control words, so they change in the same frame that valid rises
  task automatic send(input logic [15:0] a, b, ad, input logic [31:0] v);
    @(posedge MCLK);
    c1 <= a;
    c2 <= b;
    pa <= ad;
    pv <= v;
    step(1);
  endtask : send

  task automatic report_and_stop();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'h0EC99215;
    bad_count = 0;
    total_checks = 0;
    RESET = 1'b1;
    {run, tog, BUF_OVERFLOW, CRC_FAIL, flt, act} = '0;
    {HW_ENABLE, OPEN_CIRCUIT, POWER_CAPPED, PRESSURE_LIMITED} = 4'h8;
    {c1, c2, sw, pr, pc, pa, pv} = '0;
    {CFG_OUT_LEN, CFG_IN_LEN} = 16'h2020;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    run <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge MCLK);
      r = $random(seed);
      q = $random(seed);
      flt <= r[5:0] & r[11:6];
      {HW_ENABLE, OPEN_CIRCUIT, POWER_CAPPED, PRESSURE_LIMITED} <= r[15:12];
      c1 <= r[31:16] & 16'hF300;
      {sw, pr} <= q;
      pc <= r[15:0];
      act <= {4{q}};
      step(2);
      chk(SWIVEL_RUN, c1[15] & HW_ENABLE);
      chk(FEEDBACK_SENSOR_TWO, c1[8] & OPEN_CIRCUIT);
      chk({POWER_CAP_ON, PRESSURE_SET_TWO}, {c1[12], c1[9]});
      chk({PRESSURE_LOOP_ON, RAMP_ON}, c1[14:13]);
      chk(SWIVEL_DEMAND, q[31:16]);
      chk({PRESSURE_DEMAND, POWER_CAP_DEMAND}, {q[15:0], r[15:0]});
      chk(IN_IMAGE[239:224], exp_status2(flt));
      chk(IN_IMAGE[254:253], {POWER_CAPPED, PRESSURE_LIMITED});
      chk(IN_IMAGE[223:96], {4{q}});
      chk(IN_IMAGE[95:32], 64'h0000000000000000);
    end
    @(posedge MCLK);
    flt <= 6'h00;
    HW_ENABLE <= 1'b1;
    send(16'h8000, 16'h0080, 16'h0005, 32'h12345678);
    chk(IN_IMAGE[251], 1'b1);
    send(16'h8000, 16'h00C0, 16'h0005, 32'h12345678);
    chk({PARAM_WRITTEN, IN_IMAGE[250]}, 2'b11);
    step(1);
    chk(PARAM_WRITTEN, 1'b0);
    // valid dropped with write mode kept: only param ready falls
    send(16'h8000, 16'h0080, 16'h0005, 32'h0BADF00D);
    chk(IN_IMAGE[251:250], 2'b10);
    // a value below the lower range limit is refused and must not be stored
    send(16'h8000, 16'h00C0, 16'h0005, 32'h80000000);
    chk({PARAM_WRITTEN, IN_IMAGE[250]}, 2'b00);
    send(16'h8000, 16'h0000, 16'h0005, 32'h0BADF00D);
    chk(IN_IMAGE[251:250], 2'b00);
    send(16'h8000, 16'h0040, 16'h0005, 32'h0BADF00D);
    chk(PARAM_WRITTEN, 1'b0);
    for (int k = 0; k < 5; k++) begin
      send(16'h8000, sel[k], (k == 4) ? 16'h2065 : 16'h0005, 32'h0);
      chk(IN_IMAGE[31:0], fexp[k]);
    end
    step(2);
    chk({READY, IN_IMAGE[255]}, 2'b11);
    for (int k = 0; k < 2; k++) begin
      @(posedge MCLK);
      {BUF_OVERFLOW, CRC_FAIL} <= 2'b01 << k;
      @(posedge MCLK);
      {BUF_OVERFLOW, CRC_FAIL} <= 2'b00;
      step(2);
      chk({BUS_FAULT, IN_IMAGE[252], READY}, 3'b100);
      send(16'h0000, 16'h0000, 16'h0005, 32'h0);
      step(1);
      chk(BUS_FAULT, 1'b0);
      send(16'h8000, 16'h0000, 16'h0005, 32'h0);
      @(posedge MCLK);
      {CFG_OUT_LEN, CFG_IN_LEN} <= k ? 16'h2021 : 16'h1F20;
      step(2);
      chk({SIZE_ALARM, READY}, 2'b10);
      @(posedge MCLK);
      {CFG_OUT_LEN, CFG_IN_LEN} <= 16'h2020;
      step(3);
      chk({SIZE_ALARM, READY}, 2'b01);
    end
    @(posedge MCLK);
    tog <= 1'b1;
    step(3 * WDOG);
    chk({READY, BUS_FAULT}, 2'b10);
    @(posedge MCLK iff !OUT_IMAGE[232]);
    tog <= 1'b0;
    step(WDOG / 2);
    chk({READY, IN_IMAGE[248]}, {1'b1, OUT_IMAGE[232]});
    step(WDOG);
    chk({READY, BUS_FAULT}, 2'b01);
    @(posedge MCLK);
    RESET <= 1'b1;
    step(1);
    chk({READY, BUS_FAULT, IN_IMAGE[255:224]}, 34'h0);
    report_and_stop();
  end
endmodule : fpic_top_bench
